//--- clk_switch_pkg.sv
// constants, register map and types for the cpu clock switch controller
// assumes an 8-bit register port on the device with a 2-bit word address
package clk_switch_pkg;

    // host clock period and derived waits
    localparam int CLK_PERIOD_NS = 4;
    localparam int HOCO_ACC_NS = 65000;
    // least wait, so round up to whole cycles
    localparam int HOCO_ACC_CYCLES = (HOCO_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_STAB_CYCLES = 8192;
    localparam int POLL_LIMIT = 64;
    localparam int TMR_W = 24;
    localparam int POLL_W = 16;

    // device register word addresses
    localparam logic [1:0] ADDR_SYS_CLK_SEL = 2'h0;
    localparam logic [1:0] ADDR_OSC_STOP = 2'h1;
    localparam logic [1:0] ADDR_OSC_MODE = 2'h2;

    // system_clock_select fields
    localparam int CPU_SRC_STATUS_BIT = 7;
    localparam int CPU_SRC_SEL_BIT = 6;
    localparam int MAIN_SRC_STATUS_BIT = 5;
    localparam int MAIN_SRC_SEL_BIT = 4;
    // stop register fields
    localparam int ONCHIP_STOP_BIT = 0;
    localparam int HS_STOP_BIT = 7;
    localparam int SUB_STOP_BIT = 6;
    // oscillator mode register fields
    localparam int EXT_MAIN_BIT = 7;
    localparam int HS_MODE_BIT = 6;
    localparam int EXT_SUB_BIT = 5;
    localparam int SUB_MODE_BIT = 4;

    // reset views of the device registers
    localparam logic [7:0] STOP_RST = 8'hC0;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] SYS_CLK_RST = 8'h00;

    typedef enum logic [2:0] {
        SRC_HOCO = 3'h0,
        SRC_XTAL_MAIN = 3'h1,
        SRC_EXT_MAIN = 3'h2,
        SRC_XTAL_SUB = 3'h3,
        SRC_EXT_SUB = 3'h4
    } src_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_MODE = 3'h1,
        ST_START = 3'h2,
        ST_STAB = 3'h3,
        ST_SEL_MAIN = 3'h4,
        ST_SEL_CPU = 3'h5,
        ST_RD = 3'h6,
        ST_WAIT = 3'h7
    } state_t;

endpackage : clk_switch_pkg

//--- wait_timer.sv
// down-counter that holds busy for a loaded number of cycles
// assumes the caller loads it once and waits for busy to fall
`timescale 1ns/1ps
`default_nettype none
module wait_timer #(
    parameter int W = 24
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic load_i,
    input wire logic [W-1:0] len_i,
    output logic busy_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } tmr_state_t;

    tmr_state_t s_q;
    tmr_state_t s_d;

    // load wins over counting so a fresh wait is never shortened
    always_comb begin
        s_d = s_q;
        if (load_i) begin
            s_d.cnt = len_i;
        end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign busy_o = (s_q.cnt != '0);
endmodule : wait_timer
`default_nettype wire

//--- clk_switch_ctrl.sv
// host-side sequencer that moves the device cpu clock between sources
// assumes single-cycle register writes and a read answered by rdata valid
//
// What this block does
// - stop on-chip oscillator only when main or cpu status reads 1.
// - stop high-speed clock only when main status 0 or cpu 1.
// - stop subsystem clock only while cpu status reads 0.
// - before main crystal: mode 1, external 0, running, stabilisation waited.
// - before external main input: mode 1, external 1, running.
// - before sub crystal: mode 1, external 0, running, stabilisation waited.
// - before external sub input: mode 1, external 1, running.
// - before on-chip oscillator: clear its stop, wait accuracy time.
// - leaving subsystem, wanted main source already running and selected.
// - stop old source only after status confirms the change.
`timescale 1ns/1ps
`default_nettype none
module clk_switch_ctrl
    import clk_switch_pkg::*;
#(
    parameter int HOCO_WAIT = clk_switch_pkg::HOCO_ACC_CYCLES,
    parameter int XTAL_WAIT = clk_switch_pkg::OSC_STAB_CYCLES,
    parameter int POLLS = clk_switch_pkg::POLL_LIMIT
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic cmd_valid_i,
    input wire clk_switch_pkg::src_t cmd_target_i,
    output logic cmd_ready_o,
    output logic done_o,
    output logic err_o,
    output clk_switch_pkg::src_t cur_src_o,
    output logic dev_wr_o,
    output logic dev_rd_o,
    output logic [1:0] dev_addr_o,
    output logic [7:0] dev_wdata_o,
    input wire logic [7:0] dev_rdata_i,
    input wire logic dev_rvalid_i
);
    import clk_switch_pkg::*;

    typedef struct packed {
        state_t st;
        src_t cur;
        src_t tgt;
        logic ph;
        logic [7:0] mode;
        logic [7:0] stop;
        logic [7:0] csel; // select register shadow, refreshed by each read
        logic [POLL_W-1:0] polls;
        logic wr;
        logic rd;
        logic [1:0] addr;
        logic [7:0] wdata;
        logic ready;
        logic done;
        logic err;
    } ctrl_state_t;

    ctrl_state_t s_q;
    ctrl_state_t s_d;
    logic tmr_load;
    logic [TMR_W-1:0] tmr_len;
    logic tmr_busy;

    function automatic logic is_sub(input src_t s);
        return (s == SRC_XTAL_SUB) || (s == SRC_EXT_SUB);
    endfunction : is_sub

    function automatic logic is_hs(input src_t s);
        return (s == SRC_XTAL_MAIN) || (s == SRC_EXT_MAIN);
    endfunction : is_hs

    function automatic logic is_ext(input src_t s);
        return (s == SRC_EXT_MAIN) || (s == SRC_EXT_SUB);
    endfunction : is_ext

    // a group already set up in the other flavour cannot be reused
    function automatic logic conflict(input src_t s, input logic [7:0] m);
        if (is_hs(s)) begin
            return m[HS_MODE_BIT] && (m[EXT_MAIN_BIT] != is_ext(s));
        end
        if (is_sub(s)) begin
            return m[SUB_MODE_BIT] && (m[EXT_SUB_BIT] != is_ext(s));
        end
        return 1'b0;
    endfunction : conflict

    // stop guard per old source, taken from the last status read
    function automatic logic may_stop(input src_t s, input logic [7:0] c);
        if (is_sub(s)) begin
            return !c[CPU_SRC_STATUS_BIT];
        end
        if (is_hs(s)) begin
            return !c[MAIN_SRC_STATUS_BIT] || c[CPU_SRC_STATUS_BIT];
        end
        return c[MAIN_SRC_STATUS_BIT] || c[CPU_SRC_STATUS_BIT];
    endfunction : may_stop

    function automatic int stop_bit(input src_t s);
        if (is_sub(s)) begin
            return SUB_STOP_BIT;
        end
        if (is_hs(s)) begin
            return HS_STOP_BIT;
        end
        return ONCHIP_STOP_BIT;
    endfunction : stop_bit

    // sequencer: configure, start, settle, select, confirm, stop old
    always_comb begin
        s_d = s_q;
        s_d.wr = 1'b0;
        s_d.rd = 1'b0;
        s_d.done = 1'b0;
        tmr_load = 1'b0;
        tmr_len = '0;
        case (s_q.st)
            ST_IDLE: begin
                if (cmd_valid_i) begin
                    s_d.tgt = cmd_target_i;
                    s_d.err = 1'b0;
                    if (cmd_target_i == s_q.cur) begin
                        s_d.done = 1'b1;
                    end else if (conflict(cmd_target_i, s_q.mode)) begin
                        s_d.err = 1'b1;
                        s_d.done = 1'b1;
                    end else begin
                        s_d.st = ST_MODE;
                    end
                end
            end
            ST_MODE: begin
                // mode bits written before any start so the pins are set up first
                if (is_hs(s_q.tgt)) begin
                    s_d.mode[HS_MODE_BIT] = 1'b1;
                    s_d.mode[EXT_MAIN_BIT] = is_ext(s_q.tgt);
                end else if (is_sub(s_q.tgt)) begin
                    s_d.mode[SUB_MODE_BIT] = 1'b1;
                    s_d.mode[EXT_SUB_BIT] = is_ext(s_q.tgt);
                end
                s_d.wr = 1'b1;
                s_d.addr = ADDR_OSC_MODE;
                s_d.wdata = s_d.mode;
                s_d.st = ST_START;
            end
            ST_START: begin
                s_d.stop[stop_bit(s_q.tgt)] = 1'b0;
                s_d.wr = 1'b1;
                s_d.addr = ADDR_OSC_STOP;
                s_d.wdata = s_d.stop;
                tmr_load = 1'b1;
                // external inputs need no settling, crystals and on-chip do
                if (s_q.tgt == SRC_HOCO) begin
                    tmr_len = TMR_W'(HOCO_WAIT);
                end else if (!is_ext(s_q.tgt)) begin
                    tmr_len = TMR_W'(XTAL_WAIT);
                end
                s_d.st = ST_STAB;
            end
            ST_STAB: begin
                if (!tmr_busy) begin
                    s_d.st = is_sub(s_q.tgt) ? ST_SEL_CPU : ST_SEL_MAIN;
                end
            end
            ST_SEL_MAIN: begin
                // main source chosen first so leaving the sub clock is safe
                s_d.csel[MAIN_SRC_SEL_BIT] = is_hs(s_q.tgt);
                s_d.wr = 1'b1;
                s_d.addr = ADDR_SYS_CLK_SEL;
                s_d.wdata = s_d.csel;
                s_d.ph = 1'b0;
                s_d.polls = '0;
                s_d.st = ST_RD;
            end
            ST_SEL_CPU: begin
                s_d.csel[CPU_SRC_SEL_BIT] = is_sub(s_q.tgt);
                s_d.wr = 1'b1;
                s_d.addr = ADDR_SYS_CLK_SEL;
                s_d.wdata = s_d.csel;
                s_d.ph = 1'b1;
                s_d.polls = '0;
                s_d.st = ST_RD;
            end
            ST_RD: begin
                s_d.rd = 1'b1;
                s_d.addr = ADDR_SYS_CLK_SEL;
                s_d.st = ST_WAIT;
            end
            ST_WAIT: begin
                if (dev_rvalid_i) begin
                    s_d.csel = dev_rdata_i;
                    if (!s_q.ph && (dev_rdata_i[MAIN_SRC_STATUS_BIT] == is_hs(s_q.tgt))) begin
                        s_d.st = ST_SEL_CPU;
                    end else if (s_q.ph &&
                                 (dev_rdata_i[CPU_SRC_STATUS_BIT] == is_sub(s_q.tgt))) begin
                        // change confirmed, old source may now be stopped
                        s_d.cur = s_q.tgt;
                        s_d.done = 1'b1;
                        s_d.st = ST_IDLE;
                        if (may_stop(s_q.cur, dev_rdata_i)) begin
                            s_d.stop[stop_bit(s_q.cur)] = 1'b1;
                            s_d.wr = 1'b1;
                            s_d.addr = ADDR_OSC_STOP;
                            s_d.wdata = s_d.stop;
                        end
                    end else if (s_q.polls == POLL_W'(POLLS - 1)) begin
                        // switch latency is bounded, so a long wait means a fault
                        s_d.err = 1'b1;
                        s_d.done = 1'b1;
                        s_d.st = ST_IDLE;
                    end else begin
                        s_d.polls = s_q.polls + POLL_W'(1);
                        s_d.st = ST_RD;
                    end
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        s_d.ready = (s_d.st == ST_IDLE);
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '{st: ST_IDLE, cur: SRC_HOCO, tgt: SRC_HOCO, ph: 1'b0,
                     mode: MODE_RST, stop: STOP_RST, csel: SYS_CLK_RST,
                     polls: '0, wr: 1'b0, rd: 1'b0, addr: 2'h0, wdata: 8'h00,
                     ready: 1'b1, done: 1'b0, err: 1'b0};
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    wait_timer #(.W(TMR_W)) u_wait (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .load_i(tmr_load),
        .len_i(tmr_len),
        .busy_o(tmr_busy)
    );

    // outputs straight from the state register
    assign cmd_ready_o = s_q.ready;
    assign done_o = s_q.done;
    assign err_o = s_q.err;
    assign cur_src_o = s_q.cur;
    assign dev_wr_o = s_q.wr;
    assign dev_rd_o = s_q.rd;
    assign dev_addr_o = s_q.addr;
    assign dev_wdata_o = s_q.wdata;

    property p_cpu_sel_write;
        @(posedge clk_i) disable iff (!rstn_i)
        (s_q.wr && s_q.addr == ADDR_SYS_CLK_SEL && s_q.ph && s_q.st == ST_RD)
            |-> (s_q.wdata[CPU_SRC_SEL_BIT] == is_sub(s_q.tgt));
    endproperty
    a_cpu_sel_write: assert property (p_cpu_sel_write)
        else $error("cpu select bit wrong");

    property p_cpu_confirm;
        @(posedge clk_i) disable iff (!rstn_i)
        (ce_i && s_q.st == ST_WAIT && dev_rvalid_i && s_q.ph &&
         dev_rdata_i[CPU_SRC_STATUS_BIT] == is_sub(s_q.tgt))
            |=> (s_q.st == ST_IDLE && done_o && cur_src_o == $past(s_q.tgt));
    endproperty
    a_cpu_confirm: assert property (p_cpu_confirm)
        else $error("cpu status not honoured");

    property p_main_confirm;
        @(posedge clk_i) disable iff (!rstn_i)
        (ce_i && s_q.st == ST_WAIT && dev_rvalid_i && !s_q.ph &&
         dev_rdata_i[MAIN_SRC_STATUS_BIT] == is_hs(s_q.tgt)) |=> (s_q.st == ST_SEL_CPU);
    endproperty
    a_main_confirm: assert property (p_main_confirm)
        else $error("main status not honoured");

    property p_onchip_stop;
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(s_q.stop[ONCHIP_STOP_BIT])
            |-> (s_q.csel[MAIN_SRC_STATUS_BIT] || s_q.csel[CPU_SRC_STATUS_BIT]);
    endproperty
    a_onchip_stop: assert property (p_onchip_stop)
        else $error("on-chip stopped while in use");

    property p_hs_stop;
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(s_q.stop[HS_STOP_BIT])
            |-> (!s_q.csel[MAIN_SRC_STATUS_BIT] || s_q.csel[CPU_SRC_STATUS_BIT]);
    endproperty
    a_hs_stop: assert property (p_hs_stop)
        else $error("high-speed stopped while in use");

    property p_sub_stop;
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(s_q.stop[SUB_STOP_BIT]) |-> !s_q.csel[CPU_SRC_STATUS_BIT];
    endproperty
    a_sub_stop: assert property (p_sub_stop)
        else $error("sub clock stopped while in use");

    property p_main_ready;
        @(posedge clk_i) disable iff (!rstn_i)
        (s_q.st == ST_SEL_MAIN && is_hs(s_q.tgt))
            |-> (s_q.mode[HS_MODE_BIT] && s_q.mode[EXT_MAIN_BIT] == is_ext(s_q.tgt)
                 && !s_q.stop[HS_STOP_BIT] && !tmr_busy);
    endproperty
    a_main_ready: assert property (p_main_ready)
        else $error("high-speed source not prepared");

    property p_sub_ready;
        @(posedge clk_i) disable iff (!rstn_i)
        (s_q.st == ST_SEL_CPU && is_sub(s_q.tgt))
            |-> (s_q.mode[SUB_MODE_BIT] && s_q.mode[EXT_SUB_BIT] == is_ext(s_q.tgt)
                 && !s_q.stop[SUB_STOP_BIT] && !tmr_busy);
    endproperty
    a_sub_ready: assert property (p_sub_ready)
        else $error("sub source not prepared");

    property p_leave_sub;
        @(posedge clk_i) disable iff (!rstn_i)
        (s_q.st == ST_SEL_CPU && !is_sub(s_q.tgt))
            |-> (s_q.csel[MAIN_SRC_STATUS_BIT] == is_hs(s_q.tgt));
    endproperty
    a_leave_sub: assert property (p_leave_sub)
        else $error("main source not selected first");

    property p_conflict;
        @(posedge clk_i) disable iff (!rstn_i)
        (ce_i && s_q.st == ST_IDLE && cmd_valid_i && cmd_target_i != s_q.cur &&
         conflict(cmd_target_i, s_q.mode)) |=> (err_o && done_o && s_q.st == ST_IDLE);
    endproperty
    a_conflict: assert property (p_conflict)
        else $error("unsupported swap not refused");
endmodule : clk_switch_ctrl
`default_nettype wire

//--- clk_dev_model.sv
// behavioural device: clock select, stop and mode registers with status lag
// assumes one-cycle strobes from the controller and word addresses 0 to 2
`timescale 1ns/1ps
`default_nettype none
module clk_dev_model
    import clk_switch_pkg::*;
#(
    parameter int F_IH = 8,
    parameter int F_MX = 10,
    parameter int F_SUB = 4,
    parameter int HOCO_WAIT = 8,
    parameter int XTAL_WAIT = 8
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [1:0] rd_lat_i,
    input wire logic stuck_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic [7:0] sel_o,
    output logic [7:0] stop_o,
    output logic [7:0] bad_o
);
    logic [7:0] mode_q;
    logic [1:0] rd_addr_q;
    int cnt5, cnt7, rd_cnt, hs_run, io_run, sb_run;

    // main source swap lag, rounded up, in old clock cycles
    function automatic int lag(input int f_old, input int f_new);
        return (f_old <= f_new) ? 2 : (2 * f_old + f_new - 1) / f_new;
    endfunction : lag

    // register file, status lag and guard checks; bad_o counts broken preconditions
    always @(posedge clk_i or negedge rstn_i) begin
        int n;
        int fm;
        logic [7:0] up;
        if (!rstn_i) begin
            sel_o <= SYS_CLK_RST;
            stop_o <= STOP_RST;
            mode_q <= MODE_RST;
            {cnt5, cnt7, rd_cnt, hs_run, io_run, sb_run} <= '0;
            rd_addr_q <= 2'h0;
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
            bad_o <= 8'h00;
        end else begin
            n = 0;
            fm = sel_o[MAIN_SRC_STATUS_BIT] ? F_MX : F_IH;
            up = wdata_i & ~stop_o;
            // run time since start, zero while stopped
            hs_run <= stop_o[HS_STOP_BIT] ? 0 : hs_run + 1;
            io_run <= stop_o[ONCHIP_STOP_BIT] ? 0 : io_run + 1;
            sb_run <= stop_o[SUB_STOP_BIT] ? 0 : sb_run + 1;
            // status follows select only after the lag; stuck freezes it
            if (!stuck_i && cnt5 > 0) begin
                cnt5 <= cnt5 - 1;
                if (cnt5 == 1) sel_o[5] <= sel_o[4];
            end
            // cpu status follows cpu select the same way
            if (!stuck_i && cnt7 > 0) begin
                cnt7 <= cnt7 - 1;
                if (cnt7 == 1) sel_o[7] <= sel_o[6];
            end
            if (wr_i && addr_i == ADDR_SYS_CLK_SEL) begin
                if (wdata_i[4] && !sel_o[4]) begin
                    n += int'(!mode_q[HS_MODE_BIT] || stop_o[HS_STOP_BIT] ||
                        (!mode_q[EXT_MAIN_BIT] && hs_run + 1 < XTAL_WAIT));
                    cnt5 <= lag(F_IH, F_MX);
                end
                if (!wdata_i[4] && sel_o[4]) begin
                    n += int'(stop_o[ONCHIP_STOP_BIT] || io_run + 1 < HOCO_WAIT);
                    cnt5 <= lag(F_MX, F_IH);
                end
                if (wdata_i[6] && !sel_o[6]) begin
                    n += int'(!mode_q[SUB_MODE_BIT] || stop_o[SUB_STOP_BIT] ||
                        (!mode_q[EXT_SUB_BIT] && sb_run + 1 < XTAL_WAIT));
                    cnt7 <= 1 + (2 * fm + F_SUB - 1) / F_SUB;
                end
                if (!wdata_i[6] && sel_o[6]) begin
                    n += int'(sel_o[5] != wdata_i[4] ||
                        (wdata_i[4] ? stop_o[HS_STOP_BIT] : stop_o[ONCHIP_STOP_BIT]));
                    cnt7 <= 3;
                end
                sel_o[6] <= wdata_i[6];
                sel_o[4] <= wdata_i[4];
            end
            // a source may only be stopped once the cpu has left it
            if (wr_i && addr_i == ADDR_OSC_STOP) begin
                n += int'(up[ONCHIP_STOP_BIT] && !(sel_o[5] || sel_o[7]));
                n += int'(up[HS_STOP_BIT] && !(!sel_o[5] || sel_o[7]));
                n += int'(up[SUB_STOP_BIT] && sel_o[7]);
                stop_o <= wdata_i;
            end
            // flavour of a group never changes once its mode is set
            if (wr_i && addr_i == ADDR_OSC_MODE) begin
                n += int'(mode_q[HS_MODE_BIT] &&
                    wdata_i[EXT_MAIN_BIT] != mode_q[EXT_MAIN_BIT]);
                n += int'(mode_q[SUB_MODE_BIT] &&
                    wdata_i[EXT_SUB_BIT] != mode_q[EXT_SUB_BIT]);
                mode_q <= wdata_i;
            end
            // read answer after a set latency; data toggles when not valid
            if (rd_i) begin
                rd_cnt <= (rd_lat_i == 2'h0) ? 1 : int'(rd_lat_i);
                rd_addr_q <= addr_i;
            end else if (rd_cnt > 0) begin
                rd_cnt <= rd_cnt - 1;
            end
            rvalid_o <= (rd_cnt == 1);
            if (rd_cnt == 1) begin
                rdata_o <= (rd_addr_q == 2'h0) ? sel_o : (rd_addr_q == 2'h1) ? stop_o :
                    (rd_addr_q == 2'h2) ? mode_q : 8'h00;
            end else begin
                rdata_o <= ~rdata_o;
            end
            bad_o <= bad_o + n[7:0];
        end
    end
endmodule : clk_dev_model
`default_nettype wire

//--- cpu_clock_switch_control_tb_top.sv
// self-checking bench: controller against the behavioural device model
// assumes short wait parameters so every switch finishes in a few dozen cycles
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_switch_control_tb_top;
    import clk_switch_pkg::*;
    typedef struct {src_t tg; logic err; src_t cur; logic s7; logic s5; logic [3:0] old;} row_t;
    logic clk_i, rstn_i, ce_i, cmd_valid_i, cmd_ready_o, done_o, err_o;
    logic dev_wr_o, dev_rd_o, dev_rvalid_i, stuck;
    src_t cmd_target_i, cur_src_o;
    logic [1:0] dev_addr_o, rd_lat;
    logic [7:0] dev_wdata_o, dev_rdata_i, sel, stop, bad;
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    // old stop bit 15 means nothing is stopped
    row_t rows[8] = '{
        '{SRC_XTAL_MAIN, 1'b0, SRC_XTAL_MAIN, 1'b0, 1'b1, 4'h0},
        '{SRC_HOCO, 1'b0, SRC_HOCO, 1'b0, 1'b0, 4'h7},
        '{SRC_XTAL_SUB, 1'b0, SRC_XTAL_SUB, 1'b1, 1'b0, 4'h0},
        '{SRC_XTAL_MAIN, 1'b0, SRC_XTAL_MAIN, 1'b0, 1'b1, 4'h6},
        '{SRC_EXT_MAIN, 1'b1, SRC_XTAL_MAIN, 1'b0, 1'b1, 4'hF},
        '{SRC_EXT_SUB, 1'b1, SRC_XTAL_MAIN, 1'b0, 1'b1, 4'hF},
        '{SRC_HOCO, 1'b0, SRC_HOCO, 1'b0, 1'b0, 4'h7},
        '{SRC_HOCO, 1'b0, SRC_HOCO, 1'b0, 1'b0, 4'hF}};

    clk_switch_ctrl #(.HOCO_WAIT(8), .XTAL_WAIT(8), .POLLS(8)) u_clk_switch_ctrl (
        .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid_i),
        .cmd_target_i(cmd_target_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
        .err_o(err_o), .cur_src_o(cur_src_o), .dev_wr_o(dev_wr_o), .dev_rd_o(dev_rd_o),
        .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o), .dev_rdata_i(dev_rdata_i),
        .dev_rvalid_i(dev_rvalid_i));
    clk_dev_model #(.HOCO_WAIT(8), .XTAL_WAIT(8)) u_clk_dev_model (
        .clk_i(clk_i), .rstn_i(rstn_i), .wr_i(dev_wr_o), .rd_i(dev_rd_o), .addr_i(dev_addr_o),
        .wdata_i(dev_wdata_o), .rd_lat_i(rd_lat), .stuck_i(stuck), .rdata_o(dev_rdata_i),
        .rvalid_o(dev_rvalid_i), .sel_o(sel), .stop_o(stop), .bad_o(bad));

    // 250 MHz clock
    always #2 clk_i = ~clk_i;

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic do_reset(input int cycles);
        @(negedge clk_i);
        rstn_i = 1'b0;
        repeat (cycles) @(negedge clk_i);
        rstn_i = 1'b1;
    endtask : do_reset

    // one command, then a bounded wait for its done pulse
    task automatic run_cmd(input src_t tg);
        int n;
        n = 0;
        chk(cmd_ready_o, 8'h01);
        @(negedge clk_i);
        cmd_valid_i = 1'b1;
        cmd_target_i = tg;
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
        while (done_o !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        chk(done_o, 8'h01);
        // the old-source stop write leaves with done, the device takes it one edge later
        @(negedge clk_i);
    endtask : run_cmd

    initial begin
        clk_i = 1'b0;
        rstn_i = 1'b0;
        ce_i = 1'b1;
        cmd_valid_i = 1'b0;
        cmd_target_i = SRC_HOCO;
        rd_lat = 2'h1;
        stuck = 1'b0;
        do_reset(16);
        // back-to-back switches, refusals and a repeat of the same target
        foreach (rows[i]) begin
            run_cmd(rows[i].tg);
            chk(err_o, rows[i].err);
            chk(cur_src_o, rows[i].cur);
            chk(sel[CPU_SRC_STATUS_BIT], rows[i].s7);
            chk(sel[MAIN_SRC_STATUS_BIT], rows[i].s5);
            if (rows[i].old != 4'hF) chk(stop[rows[i].old], 8'h01);
            chk(bad, 8'h00);
            chk(bad, 8'h00);
            $display("row %0d done", i);
        end
        // second reset mid-run, then external inputs with slow read answers
        rd_lat = 2'h3;
        do_reset(4);
        chk(cmd_ready_o, 8'h01);
        chk(err_o | done_o | dev_wr_o | dev_rd_o, 8'h00);
        chk({6'h00, dev_addr_o} | dev_wdata_o, 8'h00);
        chk(cur_src_o, SRC_HOCO);
        chk(stop, STOP_RST);
        run_cmd(SRC_EXT_MAIN);
        chk(cur_src_o, SRC_EXT_MAIN);
        chk(sel[MAIN_SRC_STATUS_BIT], 8'h01);
        run_cmd(SRC_EXT_SUB);
        chk(cur_src_o, SRC_EXT_SUB);
        chk(stop[HS_STOP_BIT], 8'h01);
        run_cmd(SRC_HOCO);
        chk(cur_src_o, SRC_HOCO);
        chk(sel, 8'h00);
        chk(bad, 8'h00);
        $display("external input test done");
        // clock enable low freezes the controller, so a standing request is not taken
        ce_i = 1'b0;
        cmd_valid_i = 1'b1;
        cmd_target_i = SRC_XTAL_SUB;
        repeat (4) @(negedge clk_i);
        chk({done_o, dev_wr_o, cmd_ready_o}, 8'h01);
        chk(cur_src_o, SRC_HOCO);
        cmd_valid_i = 1'b0;
        ce_i = 1'b1;
        @(negedge clk_i);
        chk({done_o, err_o, dev_wr_o, dev_rd_o}, 8'h00);
        $display("clock enable test done");
        // status never confirms: controller must give up and keep its belief
        stuck = 1'b1;
        run_cmd(SRC_EXT_MAIN);
        chk(err_o, 8'h01);
        chk(cur_src_o, SRC_HOCO);
        $display("timeout test done");
        end_of_test();
    end
endmodule : cpu_clock_switch_control_tb_top
`default_nettype wire
